//--- bench/mpl_loop_monitor.sv
// Purpose: Port checker for the regulation core
// Assumes: One clock, asynchronous active-high reset
// Notes: Shadows CTRL and OCL writes to know the expected pin state
module mpl_loop_monitor import mpl_pkg::*; #(
  parameter int NPH = 8,
  parameter int PER = 64
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire mpl_pkg::mpl_apb_req_t apb_i,
  input wire mpl_pkg::mpl_apb_rsp_t apb_o,
  input wire logic [$clog2(NPH)-1:0] cur_sel_o,
  input wire mpl_pkg::mpl_smp_t cur_i,
  input wire mpl_pkg::mpl_smp_t vout_i,
  input wire logic [NPH-1:0] pwm_o,
  input wire logic [NPH-1:0] pwm_oe_n_o,
  input wire logic oc_o,
  input wire logic hspb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ctrl_r;
  logic [15:0] ocl_r;
  logic wr_c;
  logic wr_o;
  logic [NPH-1:0] act;
  assign wr_c = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite && apb_i.paddr == A_CTRL;
  assign wr_o = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite && apb_i.paddr == A_OCL;
  // Driven phases: none while disabled, else the clamped power-of-two count
  assign act = ctrl_r[C_EN] ? NPH'((1 << ((1 << ctrl_r[5:4]) > NPH ? NPH : (1 << ctrl_r[5:4]))) - 1) : '0;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= CTRL_RST;
      ocl_r <= OCL_RST;
    end else begin
      if (wr_c) ctrl_r <= apb_i.pwdata;
      if (wr_o) ocl_r <= apb_i.pwdata[15:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_APB_ZERO_WAIT: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
    else $error("no ready in access cycle");
  AST_READY_PULSE: assert property (apb_o.pready |=> !apb_o.pready)
    else $error("ready held too long");
  AST_ERR_READS_ZERO: assert property (apb_o.pready && apb_o.pslverr |-> apb_o.prdata == '0)
    else $error("refused read returned data");
  AST_SEL_HOLD: assert property (!cur_i.valid && !wr_c && !$past(wr_c) |=> $stable(cur_sel_o))
    else $error("converter select moved without sample");
  AST_SEL_STEP: assert property (cur_i.valid && !wr_c && !$past(wr_c) |=>
    cur_sel_o == $past(cur_sel_o) + 1'b1 || cur_sel_o == '0)
    else $error("converter select skipped a phase");
  AST_OE_LAG: assert property (wr_c |-> ##2 pwm_oe_n_o == ~act)
    else $error("output enables late after control write");
  AST_OE_MASK: assert property ($stable(ctrl_r) [*3] |-> pwm_oe_n_o == ~act)
    else $error("output enables disagree with active phases");
  AST_IDLE_LOW: assert property ($stable(ctrl_r) [*4] |-> (pwm_o & ~act) == '0)
    else $error("pulse on an inactive phase");
  AST_HS_GATED: assert property (!ctrl_r[C_HSEN] [*3] |-> !hspb_o)
    else $error("phase skip active while disabled");
  AST_OC_CEIL: assert property (ocl_r == 16'hffff [*3] |-> !oc_o)
    else $error("over-current above full-scale limit");
  cover property (hspb_o);
  cover property (oc_o);
  cover property (apb_o.pready && apb_o.pslverr);
endmodule

//--- bench/mpl_loop_tb_top.sv
// Purpose: Self-checking bench for the regulation core
// Assumes: Eight phases, 64 ticks per period
// Notes: Stage model supplies the phase current samples
module mpl_loop_tb_top import mpl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  mpl_apb_req_t req = '0;
  mpl_apb_rsp_t rsp;
  mpl_smp_t cur;
  mpl_smp_t vout = '0;
  logic [2:0] sel;
  logic [7:0] pwm;
  logic [7:0] oe_n;
  logic oc;
  logic hs;
  logic [8:0] obs;
  logic run = 1'b0;
  logic [1:0] gap = 2'd1;
  logic [11:0] vlev = '0;
  logic [2:0] vc = '0;
  logic [31:0] q;
  logic [7:0] msk [4] = '{8'h01, 8'h03, 8'h0f, 8'hff};
  int errors = 0;
  int checks_done = 0;
  assign obs = {hs, pwm};
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    vc <= vc + 3'd1;
    vout <= '{valid: vc == 3'd0, data: vlev};
  end
  mpl_loop mpl_loop_inst (.clk_i(clk_i), .reset_i(reset_i), .apb_i(req), .apb_o(rsp), .cur_sel_o(sel),
    .cur_i(cur), .vout_i(vout), .pwm_o(pwm), .pwm_oe_n_o(oe_n), .oc_o(oc), .hspb_o(hs));
  mpl_stage_model mpl_stage_model_inst (.clk_i(clk_i), .reset_i(reset_i), .run_i(run), .gap_i(gap),
    .pwm_i(pwm), .oe_n_i(oe_n), .sel_i(sel), .cur_o(cur));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = rsp.prdata;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic till(input int b, input logic v, inout int n);
    while (obs[b] !== v && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000) errors++;
  endtask
  task automatic t_reset();
    chk(32'(oe_n), 32'hff);
    chk(32'({pwm, oc, hs}), '0);
    apb(1'b0, A_CTRL, '0, q);
    chk(q, CTRL_RST);
    apb(1'b0, A_PID, '0, q);
    chk(q, PID_RST);
    apb(1'b0, A_LL, '0, q);
    chk(q, LL_RST);
    apb(1'b0, A_OCL, '0, q);
    chk(q, 32'(OCL_RST));
    apb(1'b1, A_DUTY, '1, q);
    apb(1'b0, A_DUTY, '0, q);
    chk(q, '0);
    apb(1'b0, 8'h40, '0, q);
    chk({q[30:0], rsp.pslverr}, 32'h1);
  endtask
  task automatic t_cal();
    for (int p = 0; p < 8; p++) apb(1'b1, A_CAL, {16'h0, 8'h20, 8'(p)}, q);
    run <= 1'b1;
    repeat (300) @(posedge clk_i);
    apb(1'b0, A_STAT, '0, q);
    chk(32'(q[15:0]), '0);
    for (int p = 0; p < 8; p++) apb(1'b1, A_CAL, 32'(p), q);
    gap <= 2'd3;
    repeat (400) @(posedge clk_i);
    apb(1'b0, A_STAT, '0, q);
    chk(32'(q[15:0] != '0), 32'h1);
    apb(1'b1, A_OCL, '0, q);
    repeat (3) @(posedge clk_i);
    chk(32'(oc), 32'h1);
    apb(1'b1, A_OCL, 32'hffff, q);
    repeat (3) @(posedge clk_i);
    chk(32'(oc), '0);
    // Freeze filters while all equal, so balance adds no correction
    run <= 1'b0;
  endtask
  task automatic t_regs();
    apb(1'b1, A_PID, '1, q);
    apb(1'b0, A_PID, '0, q);
    chk(q, 32'hffff_ffff);
    apb(1'b1, A_PID, 32'h0000_1018, q);
    apb(1'b1, A_LL, 32'h0000_ffff, q);
    apb(1'b0, A_LL, '0, q);
    chk(q, 32'h0000_ffff);
    apb(1'b1, A_LL, LL_RST, q);
  endtask
  task automatic t_phases();
    int n;
    int s;
    apb(1'b1, A_TGT, 32'h400, q);
    vlev <= 12'h3c0;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_CTRL, 32'h401 | (c << 4), q);
      apb(1'b0, A_STAT, '0, q);
      chk(32'(q[23:16]), 32'(msk[c]));
      chk(32'(oe_n), {24'h000000, ~msk[c]});
    end
    repeat (200) @(posedge clk_i);
    n = 0;
    till(0, 1'b0, n);
    till(0, 1'b1, n);
    n = 0;
    till(1, 1'b1, n);
    chk(n, PER_DEF / 8);
    vlev <= 12'h400;
    repeat (1500) @(posedge clk_i);
    apb(1'b0, A_DUTY, '0, q);
    s = 0;
    till(0, 1'b0, n);
    for (int k = 0; k < 8; k++) begin
      till(0, 1'b1, n);
      n = 0;
      till(0, 1'b0, n);
      s += n;
    end
    chk(s, q);
  endtask
  task automatic t_hspb();
    int n;
    apb(1'b1, A_CTRL, 32'h435, q);
    vlev <= 12'h000;
    n = 0;
    till(8, 1'b1, n);
    apb(1'b0, A_STAT, '0, q);
    chk(32'({q[24], hs}), 32'h3);
    vlev <= 12'h400;
    n = 0;
    till(8, 1'b0, n);
    chk(32'(hs), '0);
  endtask
  task automatic end_of_test();
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_cal();
    t_regs();
    t_phases();
    t_hspb();
    end_of_test();
  end
endmodule
bind mpl_loop mpl_loop_monitor #(.NPH(NPH), .PER(PER)) mpl_loop_monitor_inst (.clk_i(clk_i), .reset_i(reset_i),
  .apb_i(apb_i), .apb_o(apb_o), .cur_sel_o(cur_sel_o), .cur_i(cur_i), .vout_i(vout_i), .pwm_o(pwm_o),
  .pwm_oe_n_o(pwm_oe_n_o), .oc_o(oc_o), .hspb_o(hspb_o));

//--- bench/mpl_stage_model.sv
// Purpose: Power stage stand-in returning per-phase current samples
// Assumes: One sample strobe every gap_i plus one clocks
// Notes: A floating stage reads only a fixed no-load offset
module mpl_stage_model import mpl_pkg::*; #(
  parameter int NPH = 8,
  parameter logic [11:0] IDLE = 12'h020
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [1:0] gap_i,
  input wire logic [NPH-1:0] pwm_i,
  input wire logic [NPH-1:0] oe_n_i,
  input wire logic [$clog2(NPH)-1:0] sel_i,
  output mpl_pkg::mpl_smp_t cur_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] amp_r [NPH];
  logic [1:0] cnt_r;
  logic vld_r;
  assign cur_o = '{valid: vld_r, data: IDLE + amp_r[sel_i]};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
      vld_r <= 1'b0;
    end else begin
      vld_r <= run_i && cnt_r == gap_i;
      cnt_r <= (cnt_r == gap_i) ? 2'd0 : cnt_r + 2'd1;
    end
  end
  // Inductor current ramps while driven high, decays while driven low, clears while floating
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      amp_r <= '{default: '0};
    end else begin
      for (int p = 0; p < NPH; p++) begin
        if (oe_n_i[p]) amp_r[p] <= '0;
        else if (pwm_i[p] && amp_r[p] < 12'h700) amp_r[p] <= amp_r[p] + 12'd1;
        else if (!pwm_i[p] && amp_r[p] != '0) amp_r[p] <= amp_r[p] - 12'd1;
      end
    end
  end
endmodule

//--- hdl/mpl_loop.sv
// Purpose: Phase current balance, filter-PID-filter compensator and PWM
// Assumes: Converter strobes are synchronous to clk_i, one tick per clock
// Notes: Pulse widths count grid ticks plus a dithered fraction
//
// Chosen here: the APB interface to the registers and the address map.

// Operation
// - Step the converter mux through each active phase in turn.
// - Low-pass filter every phase current before balancing.
// - Balance works for 1, 2, 4 or 8 active phases, correcting active phases only.
// - In transients, adaptively skip the hottest phase to reorder firing.
// - Back in steady state, restore the fixed firing order.
// - Per-phase gain offset skews that phase's balance target.
// - Subtract stored per-phase calibration offset from each current.
// - Total current, over-current test and telemetry use stored scale factors.
// - Load line enable low removes load line droop.
// - Load line codes step 0.025 or 0.050 milliohm per loop.
// - Error passes LPF, pole one, PID, pole two in order.
// - Gains and pole locations are software configurable.
// - Each gain is a 6-bit code decoded into an effective gain.
// - Gains and filters rescale as phase count changes.
// - Pulses combine compensator output and balance corrections, active phases only.
// - Pulse edges sit on a whole grid tick.
// - Dither across periods gives one eighth tick resolution.
// - Outputs float while disabled.
// - Active phases are spaced evenly over the period.
module mpl_loop #(
  parameter int NPH = mpl_pkg::NPH_DEF,
  parameter int PER = mpl_pkg::PER_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire mpl_pkg::mpl_apb_req_t apb_i,
  output mpl_pkg::mpl_apb_rsp_t apb_o,
  output logic [$clog2(NPH)-1:0] cur_sel_o,
  input wire mpl_pkg::mpl_smp_t cur_i,
  input wire mpl_pkg::mpl_smp_t vout_i,
  output logic [NPH-1:0] pwm_o,
  output logic [NPH-1:0] pwm_oe_n_o,
  output logic oc_o,
  output logic hspb_o
);
  import mpl_pkg::*;
  localparam int PW = $clog2(NPH);
  localparam int TW = $clog2(PER);
  localparam int DW = TW + DITH_BITS;
  localparam logic signed [31:0] DMAX = 32'((PER * DITH_STEPS) - 1);

  if (NPH < 2 || NPH > 8 || (NPH & (NPH - 1)) != 0) begin : g_bad_nph
    $error("NPH must be 2, 4 or 8");
  end
  if (PER < 16 || (PER & (PER - 1)) != 0 || DITH_STEPS != 8) begin : g_bad_per
    $error("PER must be a power of two of at least 16");
  end

  logic [31:0] ctrl_r, pid_r, ll_r;
  logic [15:0] tgt_r, ocl_r, itel_r;
  logic [DW-1:0] duty_r;
  logic [31:0] rd_mux;
  logic hit;
  logic setup, wr_acc;
  logic [1:0] ncode;
  logic [NPH-1:0] act;
  logic [PW:0] nact;

  // Bus slave
  assign setup = apb_i.psel & ~apb_i.penable;
  assign wr_acc = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_o.pready;

  always_comb begin
    hit = 1'b1;
    case (apb_i.paddr)
      A_CTRL: rd_mux = ctrl_r;
      A_PID: rd_mux = pid_r;
      A_LL: rd_mux = ll_r;
      A_TGT: rd_mux = {16'h0000, tgt_r};
      A_CAL: rd_mux = 32'h0000_0000;
      A_STAT: rd_mux = {7'h00, hspb_o, 8'(act), itel_r};
      A_DUTY: rd_mux = 32'(duty_r);
      A_OCL: rd_mux = {16'h0000, ocl_r};
      default: begin
        rd_mux = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      apb_o <= '0;
    end else begin
      apb_o.pready <= setup;
      if (setup) begin
        apb_o.prdata <= rd_mux;
        apb_o.pslverr <= ~hit;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= CTRL_RST;
      pid_r <= PID_RST;
      ll_r <= LL_RST;
      tgt_r <= TGT_RST;
      ocl_r <= OCL_RST;
    end else if (wr_acc) begin
      case (apb_i.paddr)
        A_CTRL: ctrl_r <= apb_i.pwdata;
        A_PID: pid_r <= apb_i.pwdata;
        A_LL: ll_r <= apb_i.pwdata;
        A_TGT: tgt_r <= apb_i.pwdata[15:0];
        A_OCL: ocl_r <= apb_i.pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Active phase set
  assign ncode = (ctrl_r[C_NPH_LO +: 2] > 2'(PW)) ? 2'(PW) : ctrl_r[C_NPH_LO +: 2];
  assign nact = (PW + 1)'(1) << ncode;
  for (genvar i = 0; i < NPH; i++) begin : g_act
    assign act[i] = (i < nact);
  end

  // Current sampling
  logic [PW-1:0] idx_r;
  logic [ADC_W-1:0] raw_r;
  logic pend_r;
  logic [15:0] cal_rd;
  logic signed [31:0] xc;
  logic signed [15:0] filt [NPH];
  logic signed [7:0] goff [NPH];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_sel_o <= '0;
      idx_r <= '0;
      raw_r <= '0;
      pend_r <= 1'b0;
    end else begin
      pend_r <= cur_i.valid;
      if (cur_i.valid) begin
        raw_r <= cur_i.data;
        idx_r <= cur_sel_o;
        cur_sel_o <= (32'(cur_sel_o) + 1 >= 32'(nact)) ? '0 : cur_sel_o + 1'b1;
      end else if (32'(cur_sel_o) >= 32'(nact)) begin
        cur_sel_o <= '0;
      end
    end
  end

  mpl_phase_mem #(.DEPTH(NPH), .W(16)) u_cal (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .we_i(wr_acc && apb_i.paddr == A_CAL),
    .waddr_i(apb_i.pwdata[PW-1:0]),
    .wdata_i({apb_i.pwdata[CAL_GO_LO +: 8], apb_i.pwdata[CAL_OFS_LO +: 8]}),
    .raddr_i(cur_sel_o),
    .rdata_o(cal_rd)
  );

  assign xc = $signed(32'(raw_r)) - $signed(32'(cal_rd[7:0]));

  // Totals and telemetry
  logic signed [31:0] itot, avg, itel_w, hi_val;
  logic [PW-1:0] hi_idx;

  always_comb begin
    itot = 32'sd0;
    hi_idx = '0;
    hi_val = 32'(filt[0]);
    for (int k = 0; k < NPH; k++) begin
      if (act[k]) begin
        itot = itot + 32'(filt[k]);
      end
      if (act[k] && 32'(filt[k]) > hi_val) begin
        hi_idx = PW'(k);
        hi_val = 32'(filt[k]);
      end
    end
  end

  assign avg = itot >>> ncode;
  assign itel_w = (itot * $signed({24'h000000, ll_r[GAIN_LO +: 8]})) >>> ll_r[SCL_LO +: 4];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      itel_r <= '0;
      oc_o <= 1'b0;
    end else begin
      itel_r <= (itel_w < 0) ? 16'h0000 : (itel_w > 32'sh0000_ffff) ? 16'hffff : itel_w[15:0];
      oc_o <= (itel_w > $signed({16'h0000, ocl_r}));
    end
  end

  // Compensator
  logic signed [31:0] droop, err, e_lpf_r, p1_r, p1_prev_r, integ_r, u, p2_r, mag;
  logic [8:0] llv;
  logic [3:0] p1sh, p2sh;
  logic signed [31:0] kp, ki, kd;

  function automatic logic signed [31:0] dec_gain(input logic [5:0] c, input logic [1:0] n);
    dec_gain = $signed((32'({1'b1, c[GC_EXP_LO-1:0]}) << c[5:GC_EXP_LO]) >> n);
  endfunction

  assign kp = dec_gain(pid_r[KP_LO +: 6], ncode);
  assign ki = dec_gain(pid_r[KI_LO +: 6], ncode);
  assign kd = dec_gain(pid_r[KD_LO +: 6], ncode);
  assign p1sh = 4'(pid_r[P1_LO +: 3]) + 4'(ncode);
  assign p2sh = 4'(pid_r[P2_LO +: 3]) + 4'(ncode);
  assign llv = ctrl_r[C_LOOP2] ? {ll_r[LL2_LO +: 8], 1'b0} : {1'b0, ll_r[LL1_LO +: 8]};
  assign droop = ctrl_r[C_LLEN] ? ((32'(itel_r) * 32'(llv)) >>> LL_SH) : 32'sd0;
  assign err = 32'(tgt_r) - droop - 32'(vout_i.data);
  assign u = (kp * p1_r + integ_r + kd * (p1_r - p1_prev_r)) >>> PID_FRAC;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      e_lpf_r <= '0;
      p1_r <= '0;
      p1_prev_r <= '0;
      integ_r <= '0;
      p2_r <= '0;
    end else if (vout_i.valid) begin
      e_lpf_r <= e_lpf_r + ((err - e_lpf_r) >>> LPF_SH);
      p1_r <= p1_r + ((e_lpf_r - p1_r) >>> p1sh);
      p1_prev_r <= p1_r;
      integ_r <= integ_r + ki * p1_r;
      p2_r <= p2_r + ((u - p2_r) >>> p2sh);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      duty_r <= '0;
    end else begin
      duty_r <= (p2_r < 0) ? '0 : (p2_r > DMAX) ? DW'(DMAX) : DW'(p2_r);
    end
  end

  // Transient detection and adaptive order
  mpl_hs_t hs_r;
  logic [4:0] calm_r;
  logic [PW-1:0] skip_r;
  logic over;

  assign mag = (e_lpf_r < 0) ? -e_lpf_r : e_lpf_r;
  assign over = ctrl_r[C_HSEN] && mag > 32'(ctrl_r[C_HTH_LO +: 4]) * HTH_STEP;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hs_r <= HS_STEADY;
      calm_r <= '0;
      skip_r <= '0;
      hspb_o <= 1'b0;
    end else begin
      hspb_o <= (hs_r == HS_TRANS);
      case (hs_r)
        HS_STEADY: begin
          calm_r <= '0;
          if (over) begin
            hs_r <= HS_TRANS;
            skip_r <= hi_idx;
          end
        end
        HS_TRANS: begin
          skip_r <= hi_idx;
          // Disable ends a transient at once
          if (!ctrl_r[C_HSEN]) begin
            hs_r <= HS_STEADY;
          end else if (over) begin
            calm_r <= '0;
          end else if (32'(calm_r) == SETTLE_CYC - 1) begin
            hs_r <= HS_STEADY;
          end else begin
            calm_r <= calm_r + 1'b1;
          end
        end
        default: hs_r <= HS_STEADY;
      endcase
    end
  end

  // Pulse generation
  logic [TW-1:0] tick_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  for (genvar i = 0; i < NPH; i++) begin : g_ph
    logic signed [31:0] tgt_i, corr_i, dph;
    logic [TW-1:0] off_i, pos_i;
    logic [DITH_BITS-1:0] acc_r;
    logic [TW:0] width_r;
    logic [DITH_BITS:0] sum_i;

    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        filt[i] <= '0;
        goff[i] <= '0;
      end else if (pend_r && idx_r == PW'(i)) begin
        filt[i] <= 16'(32'(filt[i]) + ((xc - 32'(filt[i])) >>> LPF_SH));
        goff[i] <= $signed(cal_rd[15:8]);
      end
    end

    assign tgt_i = avg + ((avg * 32'(goff[i])) >>> GO_SH);
    assign corr_i = act[i] ? ((tgt_i - 32'(filt[i])) >>> BAL_SH) : 32'sd0;
    assign dph = 32'(duty_r) + corr_i;
    assign off_i = TW'((32'(i) * PER) >> ncode);
    assign pos_i = tick_r - off_i;
    assign sum_i = (DITH_BITS + 1)'(acc_r) + ((dph < 0) ? '0 : (DITH_BITS + 1)'(dph[DITH_BITS-1:0]));

    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        acc_r <= '0;
        width_r <= '0;
      end else if (pos_i == '0) begin
        acc_r <= sum_i[DITH_BITS-1:0];
        if (dph <= 0) begin
          width_r <= '0;
        end else if (dph > DMAX) begin
          width_r <= (TW + 1)'(PER);
        end else begin
          width_r <= (TW + 1)'(dph >>> DITH_BITS) + (TW + 1)'(sum_i[DITH_BITS]);
        end
      end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        pwm_o[i] <= 1'b0;
        pwm_oe_n_o[i] <= 1'b1;
      end else begin
        pwm_oe_n_o[i] <= ~(ctrl_r[C_EN] & act[i]);
        pwm_o[i] <= ctrl_r[C_EN] & act[i] & (32'(pos_i) < 32'(width_r))
          & ~(hs_r == HS_TRANS && skip_r == PW'(i));
      end
    end
  end
endmodule

//--- hdl/mpl_phase_mem.sv
// Purpose: Per-phase calibration store with registered read data
// Assumes: One write port, one read port, same clock
// Notes: Contents are undefined until software writes them
module mpl_phase_mem #(
  parameter int DEPTH = 8,
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

//--- include/mpl_pkg.sv
// Purpose: Shared constants and carriers for the multiphase regulation core
// Assumes: 32-bit APB, one grid tick of the pulse timer per clock
// Notes: Register offsets are byte addresses, one word each
package mpl_pkg;
  localparam int ADC_W = 12;
  localparam int NPH_DEF = 8;
  localparam int PER_DEF = 64;
  // Pulse edge grid and dithered step, in picoseconds
  localparam int GRID_PS = 1300;
  localparam int DITHER_PS = 163;
  localparam int DITH_STEPS = (GRID_PS + DITHER_PS - 1) / DITHER_PS;
  localparam int DITH_BITS = $clog2(DITH_STEPS);
  localparam int SETTLE_CYC = 16;
  localparam int LPF_SH = 2;
  localparam int BAL_SH = 2;
  localparam int GO_SH = 4;
  localparam int PID_FRAC = 6;
  localparam int LL_SH = 6;
  localparam int HTH_STEP = 4;
  // Register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PID = 8'h04;
  localparam logic [7:0] A_LL = 8'h08;
  localparam logic [7:0] A_TGT = 8'h0c;
  localparam logic [7:0] A_CAL = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_DUTY = 8'h18;
  localparam logic [7:0] A_OCL = 8'h1c;
  // Control fields
  localparam int C_EN = 0;
  localparam int C_LLEN = 1;
  localparam int C_HSEN = 2;
  localparam int C_LOOP2 = 3;
  localparam int C_NPH_LO = 4;
  localparam int C_HTH_LO = 8;
  // Compensator fields, 6-bit gain codes and 3-bit pole shifts
  localparam int KP_LO = 0;
  localparam int KI_LO = 8;
  localparam int KD_LO = 16;
  localparam int P1_LO = 24;
  localparam int P2_LO = 28;
  localparam int GC_EXP_LO = 3;
  // Load line and current scaling fields
  localparam int LL1_LO = 0;
  localparam int LL2_LO = 8;
  localparam int GAIN_LO = 16;
  localparam int SCL_LO = 24;
  // Per-phase calibration write fields, then the status phase skip bit
  localparam int CAL_OFS_LO = 8;
  localparam int CAL_GO_LO = 16;
  localparam int ST_HS = 24;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0436;
  localparam logic [31:0] PID_RST = 32'h3300_1018;
  localparam logic [31:0] LL_RST = 32'h0410_0000;
  localparam logic [15:0] TGT_RST = 16'h0000;
  localparam logic [15:0] OCL_RST = 16'hffff;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mpl_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mpl_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [ADC_W-1:0] data;
  } mpl_smp_t;

  typedef enum logic {HS_STEADY, HS_TRANS} mpl_hs_t;
endpackage
